// >>> rtl/cmp_cfg_pkg.sv
/*
  constants for the dual comparator control block: register map,
  field positions, reset values, mode codes and timing.
  assumes a 10 MHz system clock.
*/
package cmp_cfg_pkg;

  localparam logic [7:0] CFG_ADDR      = 8'h1F;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h20;
  localparam logic [7:0] IRQ_CLR_ADDR  = 8'h21;
  localparam logic [7:0] IRQ_EN_ADDR   = 8'h22;
  localparam logic [7:0] DIR_ADDR      = 8'h23;

  localparam int BIT_TWO_RESULT = 7;
  localparam int BIT_ONE_RESULT = 6;
  localparam int BIT_TWO_POL    = 5;
  localparam int BIT_ONE_POL    = 4;
  localparam int BIT_SWITCH     = 3;
  localparam int MODE_HI        = 2;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;

  // event bits: 0 result one changed, 1 result two changed, 2 settled
  localparam int EV_ONE    = 0;
  localparam int EV_TWO    = 1;
  localparam int EV_SETTLE = 2;

  typedef enum logic [2:0] {
    MODE_0 = 3'b000,
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101,
    MODE_6 = 3'b110,
    MODE_7 = 3'b111
  } cmp_mode_t;

  // minus and plus input source selectors
  localparam logic [2:0] SEL_PIN0 = 3'h0;
  localparam logic [2:0] SEL_PIN1 = 3'h1;
  localparam logic [2:0] SEL_PIN2 = 3'h2;
  localparam logic [2:0] SEL_PIN3 = 3'h3;
  localparam logic [2:0] SEL_VREF = 3'h4;
  localparam logic [2:0] SEL_OFF  = 3'h7;

  localparam int CLK_HZ         = 10_000_000;
  localparam int SETTLE_NS      = 10_000;
  localparam int SETTLE_CYCLES  = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage

// >>> rtl/dual_comparator_config.sv
/*
  control and status for two analog comparators: configuration register,
  minus input routing, synchronised results with polarity, event interrupt.
  assumes analog cores outside drive asynchronous result levels and act
  on the select codes; software uses a one-cycle strobe register port.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/10ps

module dual_comparator_config
  import cmp_cfg_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       raw_one,
  input  wire logic       raw_two,
  output logic      [2:0] one_minus_sel,
  output logic      [2:0] two_minus_sel,
  output logic      [2:0] one_plus_sel,
  output logic      [2:0] two_plus_sel,
  output logic      [3:0] pin_dir,
  output logic            result_valid,
  output logic            irq
);
  import cmp_cfg_pkg::*;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  dir;
    logic [2:0]  stat;
    logic [2:0]  en;
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [1:0]  res;
    logic [15:0] settle;
    logic        valid;
    logic [7:0]  rdata;
    logic [2:0]  one_m;
    logic [2:0]  two_m;
    logic [2:0]  one_p;
    logic [2:0]  two_p;
    logic        irq;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [1:0] pol_res;
  logic [2:0] ev;
  logic [2:0] mode_w;
  logic       sw;
  logic [2:0] om;
  logic [2:0] tm;
  logic [2:0] op;
  logic [2:0] tp;

  always_comb
  begin
    st_next = st_reg;
    // second stage only feeds logic; first stage read by second alone
    st_next.s1 = {raw_two, raw_one};
    st_next.s2 = st_reg.s1;
    pol_res = st_reg.s2 ^ st_reg.cfg[BIT_TWO_POL:BIT_ONE_POL];
    st_next.res = pol_res;
    ev = 3'b000;

    // register writes
    if (wr)
    begin
      case (addr)
        CFG_ADDR:
        begin
          // result bits are read-only, keep stored values
          st_next.cfg[5:0] = wdata[5:0];
          if (wdata[MODE_HI:0] != st_reg.cfg[MODE_HI:0])
          begin
            st_next.valid  = 1'b0;
            st_next.settle = SETTLE[15:0];
          end
        end
        DIR_ADDR:     st_next.dir = wdata;
        IRQ_EN_ADDR:  st_next.en = wdata[2:0];
        IRQ_CLR_ADDR: st_next.stat = st_reg.stat & ~wdata[2:0];
        default:      st_next.dir = st_reg.dir;
      endcase
    end

    // settling countdown after a mode change
    if (!st_reg.valid && !(wr && addr == CFG_ADDR && wdata[MODE_HI:0] != st_reg.cfg[MODE_HI:0]))
    begin
      if (st_reg.settle <= 16'h0001)
      begin
        st_next.valid  = 1'b1;
        st_next.settle = 16'h0000;
        ev[EV_SETTLE]  = 1'b1;
      end
      else
        st_next.settle = st_reg.settle - 16'h0001;
    end

    // result change events only while results are trusted
    if (st_reg.valid)
      ev[1:0] = pol_res ^ st_reg.res;

    st_next.cfg[BIT_TWO_RESULT] = pol_res[1];
    st_next.cfg[BIT_ONE_RESULT] = pol_res[0];

    // set wins over a same-cycle clear
    st_next.stat = st_next.stat | ev;

    // minus/plus routing by mode
    mode_w = st_next.cfg[MODE_HI:0];
    sw     = st_next.cfg[BIT_SWITCH];
    om = SEL_OFF;
    tm = SEL_OFF;
    op = SEL_OFF;
    tp = SEL_OFF;
    case (cmp_mode_t'(mode_w))
      // both cores on pins, switch bit has no effect here
      MODE_0:
      begin
        om = SEL_PIN0;
        tm = SEL_PIN1;
        op = SEL_PIN3;
        tp = SEL_PIN2;
      end
      MODE_1:
      begin
        om = sw ? SEL_PIN3 : SEL_PIN0;
        op = SEL_PIN2;
        tm = SEL_PIN1;
        tp = SEL_PIN2;
      end
      MODE_2:
      begin
        om = sw ? SEL_PIN3 : SEL_PIN0;
        tm = sw ? SEL_PIN2 : SEL_PIN1;
        op = SEL_VREF;
        tp = SEL_VREF;
      end
      // remaining modes keep fixed routes whatever the switch holds
      MODE_3:
      begin
        om = SEL_PIN0;
        tm = SEL_PIN1;
        op = SEL_PIN2;
        tp = SEL_PIN2;
      end
      MODE_4:
      begin
        om = SEL_PIN0;
        tm = SEL_PIN1;
        op = SEL_PIN3;
        tp = SEL_PIN2;
      end
      MODE_5:
      begin
        tm = SEL_PIN1;
        tp = SEL_PIN2;
      end
      MODE_6:
      begin
        om = SEL_PIN0;
        tm = SEL_PIN1;
        op = SEL_PIN2;
        tp = SEL_PIN2;
      end
      MODE_7: ;
      default: ;
    endcase
    st_next.one_m = om;
    st_next.two_m = tm;
    st_next.one_p = op;
    st_next.two_p = tp;

    st_next.irq = |(st_next.stat & st_next.en);

    // read data stands one cycle after the strobe only
    st_next.rdata = 8'h00;
    if (rd)
    begin
      case (addr)
        CFG_ADDR:      st_next.rdata = st_reg.cfg;
        DIR_ADDR:      st_next.rdata = st_reg.dir;
        IRQ_STAT_ADDR: st_next.rdata = {5'h00, st_reg.stat};
        IRQ_EN_ADDR:   st_next.rdata = {5'h00, st_reg.en};
        default:       st_next.rdata = 8'h00;
      endcase
    end
  end

  // state register, every output comes from here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= '0;
      st_reg.cfg   <= CFG_RESET;
      st_reg.dir   <= DIR_RESET;
      st_reg.valid <= 1'b1;
      st_reg.one_m <= SEL_PIN0;
      st_reg.two_m <= SEL_PIN1;
      st_reg.one_p <= SEL_PIN3;
      st_reg.two_p <= SEL_PIN2;
    end
    else
      st_reg <= st_next;
  end

  assign rdata         = st_reg.rdata;
  assign one_minus_sel = st_reg.one_m;
  assign two_minus_sel = st_reg.two_m;
  assign one_plus_sel  = st_reg.one_p;
  assign two_plus_sel  = st_reg.two_p;
  assign pin_dir       = st_reg.dir[3:0];
  assign result_valid  = st_reg.valid;
  assign irq           = st_reg.irq;

  a_mode_one_route: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b001) |-> (st_reg.one_m == (st_reg.cfg[3] ? SEL_PIN3 : SEL_PIN0)))
    else $error("mode one routing wrong");

  a_mode_two_route: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b010) |-> (st_reg.two_m == (st_reg.cfg[3] ? SEL_PIN2 : SEL_PIN1)))
    else $error("mode two routing wrong");

  a_result_two_pol: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.cfg[7] == ($past(st_reg.s2[1]) ^ $past(st_reg.cfg[5])))
    else $error("result two polarity wrong");

  a_result_one_pol: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.cfg[6] == ($past(st_reg.s2[0]) ^ $past(st_reg.cfg[4])))
    else $error("result one polarity wrong");

  a_sync_depth: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(raw_one) ##1 raw_one [*2] |-> st_reg.s2[0])
    else $error("sync depth wrong");

  a_mode_invalid: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == CFG_ADDR && wdata[2:0] != st_reg.cfg[2:0]) |=> !result_valid)
    else $error("mode change not flagged");

  a_direction_copy: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == DIR_ADDR) |=> pin_dir == $past(wdata[3:0]))
    else $error("direction not taken");

  a_polarity_store: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == CFG_ADDR) |=> st_reg.cfg[5:3] == $past(wdata[5:3]))
    else $error("control bits not stored");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(st_reg.stat & st_reg.en))
    else $error("irq mismatch");

  // register port: read data stand one cycle, zero otherwise
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data not idle");

  a_cfg_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == CFG_ADDR) |=> rdata == $past(st_reg.cfg))
    else $error("config read wrong");

  a_dir_read: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && addr == DIR_ADDR) |=> rdata == $past(st_reg.dir))
    else $error("direction read wrong");

  // directions only move on their own register, never on a mode write
  a_dir_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == DIR_ADDR) |=> $stable(pin_dir))
    else $error("direction moved");

  // result bits are read-only, a config write must not reach them
  a_result_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == CFG_ADDR) |=> st_reg.cfg[7:6] == $past(pol_res))
    else $error("result bits written");

  a_sync_stage: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg.s2 == $past(st_reg.s1))
    else $error("second stage skipped");

  // routing per mode
  a_mode_zero_route: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b000) |-> (st_reg.one_m == SEL_PIN0 && st_reg.two_m == SEL_PIN1))
    else $error("mode zero routing wrong");

  a_mode_two_vref: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b010) |-> (st_reg.one_p == SEL_VREF && st_reg.two_p == SEL_VREF))
    else $error("reference not selected");

  a_mode_two_one: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b010) |-> (st_reg.one_m == (st_reg.cfg[3] ? SEL_PIN3 : SEL_PIN0)))
    else $error("mode two first minus wrong");

  a_mode_three_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b011) |-> (st_reg.one_m == SEL_PIN0 && st_reg.two_m == SEL_PIN1))
    else $error("switch leaked into mode three");

  a_mode_off: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg.cfg[2:0] == 3'b111) |-> (st_reg.one_m == SEL_OFF && st_reg.two_m == SEL_OFF
      && st_reg.one_p == SEL_OFF && st_reg.two_p == SEL_OFF))
    else $error("off mode still routed");

  // settling window and its event
  a_settle_event: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(result_valid) |-> st_reg.stat[EV_SETTLE])
    else $error("settle event missing");

  a_same_mode_valid: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == CFG_ADDR && wdata[2:0] == st_reg.cfg[2:0] && result_valid) |=> result_valid)
    else $error("same mode restarted settling");

  a_settle_load: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == CFG_ADDR && wdata[2:0] != st_reg.cfg[2:0]) |=> st_reg.settle == SETTLE[15:0])
    else $error("settle count not loaded");

  // a clear in the cycle of a new event must lose
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && addr == IRQ_CLR_ADDR && wdata[EV_SETTLE] && ev[EV_SETTLE]) |=> st_reg.stat[EV_SETTLE])
    else $error("clear beat new event");

endmodule

// >>> test/comparator_pair_model.sv
/*
  behavioural pair of analog comparators behind the control block.
  assumes select codes 0..3 for pins, 4 for the reference, others off.
*/
`timescale 1ns/10ps
module comparator_pair_model
(
  input  wire logic [4:0][3:0] level,
  input  wire logic [2:0]      one_plus_sel,
  input  wire logic [2:0]      one_minus_sel,
  input  wire logic [2:0]      two_plus_sel,
  input  wire logic [2:0]      two_minus_sel,
  output logic                 raw_one,
  output logic                 raw_two
);
  // an open input leaves its comparator low rather than floating
  function automatic logic cmp(input logic [4:0][3:0] lv, input logic [2:0] p, input logic [2:0] m);
    if (p > 3'h4 || m > 3'h4)
      return 1'b0;
    return lv[p] > lv[m];
  endfunction
  // two cores, four pins and the reference as sources
  assign raw_one = cmp(level, one_plus_sel, one_minus_sel);
  assign raw_two = cmp(level, two_plus_sel, two_minus_sel);
endmodule

// >>> test/dual_comparator_config_bench.sv
/*
  self-checking bench for the dual comparator control block.
  assumes the comparator model and a settling count shortened to 4.
*/
`timescale 1ns/10ps
module dual_comparator_config_bench;
  import cmp_cfg_pkg::*;
  typedef struct packed {logic [7:0] cfg; logic [2:0] one; logic [2:0] two; logic both;} row_t;
  logic            clk = 0, rst_n = 0, wr = 0, rd = 0, raw_one, raw_two, result_valid, irq;
  logic [7:0]      addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [2:0]      om, tm, op, tp;
  logic [3:0]      pin_dir;
  logic [4:0][3:0] level = '{default: 4'h8};
  int              n_errors = 0, compares = 0, cyc = 0;
  row_t            rows[4] = '{'{8'h01, 3'h0, 3'h0, 1'b0}, '{8'h09, 3'h3, 3'h0, 1'b0},
                               '{8'h02, 3'h0, 3'h1, 1'b1}, '{8'h0A, 3'h3, 3'h2, 1'b1}};
  always #50 clk = ~clk;
  dual_comparator_config #(.SETTLE(4)) DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .raw_one(raw_one), .raw_two(raw_two), .one_minus_sel(om),
    .two_minus_sel(tm), .one_plus_sel(op), .two_plus_sel(tp), .pin_dir(pin_dir),
    .result_valid(result_valid), .irq(irq));
  comparator_pair_model u_cmp (.level(level), .one_plus_sel(op), .one_minus_sel(om), .two_plus_sel(tp),
    .two_minus_sel(tm), .raw_one(raw_one), .raw_two(raw_two));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait, the settle count is short in simulation
  task wait_valid;
    int k;
    k = 0;
    while (result_valid !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    chk({7'h00, result_valid}, 8'h01);
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, the whole run needs well under 200 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({4'h0, pin_dir}, 8'h0F);
    chk({7'h00, irq}, 8'h00);
    rd_reg(CFG_ADDR);
    chk(d, CFG_RESET);
    // table rows: mode and switch against routing
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(CFG_ADDR, rows[i].cfg);
      #1 chk({5'h00, om}, {5'h00, rows[i].one});
      if (rows[i].both)
        chk({5'h00, tm}, {5'h00, rows[i].two});
      if (i % 2 == 0)
        chk({7'h00, result_valid}, 8'h00);
      wait_valid();
    end
    wr_reg(DIR_ADDR, 8'h05);
    #1 chk({4'h0, pin_dir}, 8'h05);
    rd_reg(8'h40);
    chk(d, 8'h00);
    wr_reg(CFG_ADDR, 8'hFF);
    #1 chk({5'h00, op}, {5'h00, SEL_OFF});
    rd_reg(CFG_ADDR);
    chk(d & 8'h3F, 8'h3F);
    // minus of one low, minus of two high: one reads 1, two reads 0
    @(posedge clk);
    level[0] <= 4'h0; level[1] <= 4'hF;
    wr_reg(IRQ_EN_ADDR, 8'h00);
    wr_reg(CFG_ADDR, 8'h02);
    #1 chk({5'h00, tp}, {5'h00, SEL_VREF});
    wait_valid();
    for (int p = 0; p < 4; p++)
    begin
      wr_reg(CFG_ADDR, {2'b00, p[1:0], 4'h2});
      repeat (4) @(posedge clk);
      rd_reg(CFG_ADDR);
      chk(d, {p[1], ~p[0], p[1:0], 4'h2});
    end
    // raise, read, clear and mask the change interrupt
    wr_reg(IRQ_EN_ADDR, 8'h03);
    wr_reg(IRQ_CLR_ADDR, 8'h07);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    level[0] <= 4'hF;
    repeat (8) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    rd_reg(IRQ_STAT_ADDR); chk(d & 8'h01, 8'h01);
    wr_reg(IRQ_CLR_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wr_reg(IRQ_EN_ADDR, 8'h00);
    level[0] <= 4'h0;
    repeat (8) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd_reg(IRQ_STAT_ADDR);
    chk(d & 8'h01, 8'h01);
    // reset in mid-run: every output back to its idle value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({5'h00, om}, {5'h00, SEL_PIN0});
    chk({5'h00, tm}, {5'h00, SEL_PIN1});
    chk({5'h00, op}, {5'h00, SEL_PIN3});
    chk({5'h00, tp}, {5'h00, SEL_PIN2});
    chk({4'h0, pin_dir}, 8'h0F);
    chk({7'h00, result_valid}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    chk(rdata, 8'h00);
    // switch bit stored but ignored in modes 000 and 011
    wr_reg(CFG_ADDR, 8'h08);
    #1 chk({5'h00, om}, {5'h00, SEL_PIN0});
    chk({5'h00, tm}, {5'h00, SEL_PIN1});
    wr_reg(CFG_ADDR, 8'h0B);
    #1 chk({5'h00, om}, {5'h00, SEL_PIN0});
    chk({7'h00, result_valid}, 8'h00);
    rd_reg(CFG_ADDR);
    chk(d & 8'h3F, 8'h0B);
    wait_valid();
    end_of_test();
  end
endmodule
